// ===== verilog/i2st_top.v
`include "i2st_regs.vh"

// Summary of operation
// - address hold stretches clock, flags matching address
// - start sets start bit, flag if enabled
// - eighth falling edge of read match holds clock
// - ack-time, read/write, data/address status readable
// - reading buffer clears buffer-full
// - drive software-selected ack after address
// - setting clock-release bit frees scl
// - after read ack, hardware holds clock, flags
// - loading transmit byte sets buffer-full
// - buffer loads refused before address ack
// - capture master ack on ninth pulse
// - master nack releases bus for stop
// - irq flag sticky until software clears
module i2st_top #(
  parameter OWN_W = 7
) (
  input  wire       core_clk_i,
  input  wire       arst_n_i,
  input  wire [3:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  input  wire       scl_i,
  output wire       scl_o,
  output wire       scl_oe_o,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe_o,
  output wire       irq_o
);

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam ST_IDLE  = 3'd0;
  localparam ST_ADDR  = 3'd1;
  localparam ST_AACK  = 3'd2;
  localparam ST_TX    = 3'd3;
  localparam ST_MACK  = 3'd4;
  localparam ST_SKIP  = 3'd5;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  reg rst_a_r;
  reg rst_n_r;

  // async assert, synchronous release
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_a_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n_r <= rst_a_r;
    end
  end

  // ---------------------------------------------------------------
  // bus line conditioning
  // ---------------------------------------------------------------
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire sda_s;

  i2st_bus_cond u_cond (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_r),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .scl_rise_o (scl_rise),
    .scl_fall_o (scl_fall),
    .start_o    (start_det),
    .stop_o     (stop_det),
    .sda_o      (sda_s)
  );

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [2:0]       state_r;
  reg [3:0]       bit_cnt_r;
  reg [7:0]       shift_r;
  reg [7:0]       buf_r;
  reg [OWN_W-1:0] own_r;
  reg             address_hold_enable_r;
  reg             sie_r;
  reg             clkrel_r;
  reg             ack_data_select_r;
  reg             bf_r;
  reg             rw_r;
  reg             da_r;
  reg             ack_time_status_r;
  reg             ackst_r;
  reg             start_r;
  reg             stop_r;
  reg [2:0]       irq_r;
  reg [2:0]       mask_r;
  reg             sda_low_r;

  // decoded register accesses
  wire wr_ctrl = wr_i & (addr_i == `I2ST_ADDR_CTRL);
  wire wr_buf  = wr_i & (addr_i == `I2ST_ADDR_BUF);
  wire wr_own  = wr_i & (addr_i == `I2ST_ADDR_OWN);
  wire wr_irq  = wr_i & (addr_i == `I2ST_ADDR_IRQ);
  wire wr_mask = wr_i & (addr_i == `I2ST_ADDR_MASK);
  wire rd_buf  = rd_i & (addr_i == `I2ST_ADDR_BUF);

  // falling scl edges only seen while clock released, rising edges always
  wire fall_ok = scl_fall & clkrel_r;
  wire rise_ok = scl_rise;

  // address match on received byte
  wire [7:0] rx_byte = {shift_r[6:0], sda_s};
  wire match = (shift_r[7:1] == own_r);

  // buffer load allowed only once address ack done
  wire load_ok = (state_r == ST_TX) || (state_r == ST_MACK);

  // events raising the sticky flag
  reg ev_flag;
  reg ev_nack;

  // ---------------------------------------------------------------
  // protocol engine
  // ---------------------------------------------------------------
  always @(posedge core_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
      buf_r     <= 8'h00;
      own_r     <= `I2ST_OWN_RST;
      address_hold_enable_r    <= 1'b0;                               // bit 0 of ctrl reset
      sie_r     <= 1'b0;
      clkrel_r  <= 1'b1;
      ack_data_select_r   <= 1'b0;
      bf_r      <= 1'b0;
      rw_r      <= 1'b0;
      da_r      <= 1'b0;
      ack_time_status_r  <= 1'b0;
      ackst_r   <= 1'b0;
      start_r   <= 1'b0;
      stop_r    <= 1'b0;
      sda_low_r <= 1'b0;
      ev_flag   <= 1'b0;
      ev_nack   <= 1'b0;
    end else begin
      ev_flag <= 1'b0;
      ev_nack <= 1'b0;
      // software control writes
      if (wr_ctrl) begin
        address_hold_enable_r  <= wdata_i[`I2ST_CTRL_HOLD_EN];
        sie_r   <= wdata_i[`I2ST_CTRL_SIE];
        ack_data_select_r <= wdata_i[`I2ST_CTRL_ACK_SEL];
        if (wdata_i[`I2ST_CTRL_CLKREL])
          clkrel_r <= 1'b1;
      end
      if (wr_own)
        own_r <= wdata_i[OWN_W-1:0];
      if (rd_buf)
        bf_r <= 1'b0;
      if (wr_buf && load_ok) begin
        buf_r <= wdata_i;
        bf_r  <= 1'b1;
      end
      if (start_det) begin
        start_r   <= 1'b1;
        stop_r    <= 1'b0;
        ev_flag   <= sie_r;
        state_r   <= ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_low_r <= 1'b0;
        ack_time_status_r  <= 1'b0;
        da_r      <= 1'b0;
      end else if (stop_det) begin
        stop_r    <= 1'b1;
        start_r   <= 1'b0;
        state_r   <= ST_IDLE;
        sda_low_r <= 1'b0;
        ack_time_status_r  <= 1'b0;
      end else begin
        case (state_r)
          ST_ADDR: begin
            if (rise_ok) begin
              shift_r   <= rx_byte;
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            if (fall_ok && bit_cnt_r == 4'h8) begin
              if (match) begin
                rw_r     <= shift_r[0];
                buf_r    <= shift_r;
                bf_r     <= 1'b1;
                ack_time_status_r <= 1'b1;
                state_r  <= ST_AACK;
                if (address_hold_enable_r || shift_r[0]) begin
                  clkrel_r <= 1'b0;
                  ev_flag  <= 1'b1;
                end else begin
                  sda_low_r <= ~ack_data_select_r;
                end
              end else begin
                state_r <= ST_SKIP;
              end
            end
          end
          ST_AACK: begin
            // set up chosen ack while scl still low, never while high
            if (bit_cnt_r != 4'h9)
              sda_low_r <= wr_ctrl ? ~wdata_i[`I2ST_CTRL_ACK_SEL]
                                   : ~ack_data_select_r;
            if (fall_ok && bit_cnt_r == 4'h9) begin
              ack_time_status_r  <= 1'b0;
              bit_cnt_r <= 4'h0;
              if (rw_r && !ack_data_select_r) begin
                clkrel_r  <= 1'b0;
                ev_flag   <= 1'b1;
                da_r      <= 1'b1;
                state_r   <= ST_TX;
                sda_low_r <= 1'b0;
              end else begin
                sda_low_r <= 1'b0;
                state_r   <= ST_SKIP;
              end
            end else if (rise_ok) begin
              bit_cnt_r <= 4'h9;
            end
          end
          ST_TX: begin
            // first bit set up while scl is still held low
            if (bit_cnt_r == 4'h0)
              sda_low_r <= ~buf_r[7];
            if (rise_ok)
              bit_cnt_r <= bit_cnt_r + 4'h1;
            if (fall_ok) begin
              if (bit_cnt_r == 4'h8) begin
                sda_low_r <= 1'b0;
                bf_r      <= 1'b0;
                state_r   <= ST_MACK;
              end else begin
                sda_low_r <= ~buf_r[3'd7 - bit_cnt_r[2:0]];
              end
            end
          end
          ST_MACK: begin
            if (rise_ok) begin
              ackst_r <= sda_s;
              if (sda_s) begin
                ev_nack <= 1'b1;
                state_r <= ST_SKIP;
              end else begin
                bit_cnt_r <= 4'h9;
              end
            end
            if (fall_ok && bit_cnt_r == 4'h9) begin
              bit_cnt_r <= 4'h0;
              clkrel_r  <= 1'b0;
              ev_flag   <= 1'b1;
              state_r   <= ST_TX;
            end
          end
          ST_SKIP: begin
            // released bus, wait for stop or start
            sda_low_r <= 1'b0;
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, set wins over clear
  // ---------------------------------------------------------------
  wire [2:0] ev_vec = {ev_nack, ev_flag & start_det & sie_r, ev_flag};

  always @(posedge core_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq_r  <= 3'h0;
      mask_r <= `I2ST_MASK_RST;
    end else begin
      irq_r <= (irq_r & ~({3{wr_irq}} & wdata_i[2:0])) | ev_vec;
      if (wr_mask)
        mask_r <= wdata_i[2:0];
    end
  end

  assign irq_o = |(irq_r & mask_r);

  // ---------------------------------------------------------------
  // read data, one cycle after strobe
  // ---------------------------------------------------------------
  always @(posedge core_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `I2ST_ADDR_CTRL: rdata_o <= {4'h0, ack_data_select_r, clkrel_r, sie_r, address_hold_enable_r};
        `I2ST_ADDR_STAT: rdata_o <= {1'b0, stop_r, start_r, ackst_r,
                                     ack_time_status_r, da_r, rw_r, bf_r};
        `I2ST_ADDR_BUF:  rdata_o <= buf_r;
        `I2ST_ADDR_OWN:  rdata_o <= {{(8-OWN_W){1'b0}}, own_r};
        `I2ST_ADDR_IRQ:  rdata_o <= {5'h00, irq_r};
        `I2ST_ADDR_MASK: rdata_o <= {5'h00, mask_r};
        default:         rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // open-drain pin drive
  // ---------------------------------------------------------------
  assign scl_o    = 1'b0;
  assign scl_oe_o = ~clkrel_r;
  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_low_r;

endmodule

// ===== verilog/i2st_regs.vh
`ifndef I2ST_REGS_VH
`define I2ST_REGS_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define I2ST_ADDR_CTRL   4'h0
`define I2ST_ADDR_STAT   4'h1
`define I2ST_ADDR_BUF    4'h2
`define I2ST_ADDR_OWN    4'h3
`define I2ST_ADDR_IRQ    4'h4
`define I2ST_ADDR_MASK   4'h5

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define I2ST_CTRL_HOLD_EN 0
`define I2ST_CTRL_SIE    1
`define I2ST_CTRL_CLKREL 2
`define I2ST_CTRL_ACK_SEL 3

// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define I2ST_STAT_FULL   0
`define I2ST_STAT_RW     1
`define I2ST_STAT_DA     2
`define I2ST_STAT_ACK_TIME 3
`define I2ST_STAT_ACKST  4
`define I2ST_STAT_START  5
`define I2ST_STAT_STOP   6

// ---------------------------------------------------------------
// interrupt status fields
// ---------------------------------------------------------------
`define I2ST_IRQ_FLAG    0
`define I2ST_IRQ_START   1
`define I2ST_IRQ_NACK    2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define I2ST_CTRL_RST    8'h04
`define I2ST_OWN_RST     7'h2a
`define I2ST_MASK_RST    3'h0

`endif

// ===== verilog/i2st_sync.v
// ---------------------------------------------------------------
// two-stage synchroniser
// ---------------------------------------------------------------
module i2st_sync #(
  parameter RST_VAL = 1'b1
) (
  input  wire core_clk_i,
  input  wire rst_n_i,
  input  wire d_i,
  output wire q_o
);
  reg meta_r;
  reg q_r;

  // first stage read only by second
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      q_r    <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_r    <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule

// ===== verilog/i2st_bus_cond.v
// ---------------------------------------------------------------
// synchronised bus lines with edge and condition detection
// ---------------------------------------------------------------
module i2st_bus_cond (
  input  wire core_clk_i,
  input  wire rst_n_i,
  input  wire scl_i,
  input  wire sda_i,
  output wire scl_rise_o,
  output wire scl_fall_o,
  output wire start_o,
  output wire stop_o,
  output wire sda_o
);
  wire scl_s;
  wire sda_s;
  reg  scl_d_r;
  reg  sda_d_r;

  i2st_sync #(.RST_VAL(1'b1)) u_scl (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .d_i        (scl_i),
    .q_o        (scl_s)
  );

  i2st_sync #(.RST_VAL(1'b1)) u_sda (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .d_i        (sda_i),
    .q_o        (sda_s)
  );

  // previous sampled levels
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // edges and start/stop while scl high
  assign scl_rise_o = scl_s & ~scl_d_r;
  assign scl_fall_o = ~scl_s & scl_d_r;
  assign start_o    = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_o     = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign sda_o      = sda_s;
endmodule

// ===== verification/i2st_top_assertions.sv
module i2st_top_assertions (
  input wire       core_clk_i,
  input wire       arst_n_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  input wire       scl_i,
  input wire       scl_o,
  input wire       scl_oe_o,
  input wire       sda_i,
  input wire       sda_o,
  input wire       sda_oe_o,
  input wire       irq_o
);
  reg [2:0] mask_r;
  reg       sie_r;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // shadow of mask and start enable
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask_r <= 3'h0;
      sie_r  <= 1'b0;
    end else if (wr_i && addr_i == 4'h5) begin
      mask_r <= wdata_i[2:0];
    end else if (wr_i && addr_i == 4'h0) begin
      sie_r  <= wdata_i[1];
    end
  end
  sequence s_rel_wr;
    wr_i && addr_i == 4'h0 && wdata_i[2];
  endsequence
  sequence s_buf_stat;
    rd_i && addr_i == 4'h2 ##2 rd_i && addr_i == 4'h1;
  endsequence
  a_clk_release: assert property (
    s_rel_wr |-> ##[1:2] !scl_oe_o)
    else $error("scl still held after release write");
  a_hold_stays: assert property (
    scl_oe_o && !(wr_i && addr_i == 4'h0 && wdata_i[2]) |=> scl_oe_o)
    else $error("scl hold dropped without release write");
  a_hold_irq: assert property (
    $rose(scl_oe_o) && mask_r[0] |-> ##[0:2] irq_o)
    else $error("clock hold without interrupt");
  a_irq_sticky: assert property (
    irq_o && !(wr_i && (addr_i == 4'h4 || addr_i == 4'h5)) |=> irq_o)
    else $error("interrupt dropped without software clear");
  a_bf_clear: assert property (
    s_buf_stat |=> !rdata_o[0])
    else $error("buffer full still set after buffer read");
  a_start_irq: assert property (
    $fell(sda_i) && scl_i && sie_r && mask_r[0] |-> ##[1:8] irq_o)
    else $error("start seen without interrupt");
  a_sda_steady: assert property (
    scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("sda changed while scl high");
  a_irq_mask: assert property (
    irq_o |-> mask_r != 3'h0)
    else $error("interrupt while fully masked");
endmodule

bind i2st_top i2st_top_assertions u_chk (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));

// ===== verification/i2st_master_model.sv
module i2st_master_model (
  input  wire scl_i,
  input  wire sda_i,
  output reg  scl_low_o,
  output reg  sda_low_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5; // 125 ns bus clock
  int errs = 0;
  // idle bus: both lines released
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  // one clock pulse; waits out slave stretching, bounded
  task automatic pulse(output logic b);
    int n;
    n = 0;
    scl_low_o = 1'b0;
    while (scl_i !== 1'b1 && n < 400) begin
      #5;
      n++;
    end
    if (n == 400) errs++;
    #(HALF);
    b = sda_i;
    scl_low_o = 1'b1;
    #(HALF);
  endtask
  task automatic send_bit(input logic d);
    logic t;
    sda_low_o = !d;
    #10;
    pulse(t);
  endtask
  task automatic get_bit(output logic b);
    sda_low_o = 1'b0;
    pulse(b);
  endtask
  task automatic start();
    sda_low_o = 1'b1;
    #(HALF);
    scl_low_o = 1'b1;
    #(HALF);
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    #10;
    scl_low_o = 1'b0;
    #(HALF);
    sda_low_o = 1'b0;
    #(HALF);
  endtask
  task automatic send_byte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) send_bit(d[i]);
  endtask
  task automatic read_byte(output logic [7:0] d);
    logic t;
    for (int i = 7; i >= 0; i--) begin
      get_bit(t);
      d[i] = t;
    end
  endtask
endmodule

// ===== verification/test_i2c_slave_tx_address_hold.sv
module test_i2c_slave_tx_address_hold;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------
  logic       core_clk_i = 1'b0;
  logic       arst_n_i   = 1'b0;
  logic [3:0] addr_i     = 4'h0;
  logic [7:0] wdata_i    = 8'h00;
  logic       wr_i       = 1'b0;
  logic       rd_i       = 1'b0;
  logic [7:0] v;
  logic       b;
  wire  [7:0] rdata_o;
  wire        scl_oe_o, sda_oe_o, irq_o, m_scl_low, m_sda_low;
  wire        scl_w      = !(scl_oe_o || m_scl_low); // pulled-up lines
  wire        sda_w      = !(sda_oe_o || m_sda_low);
  int         fails      = 0;
  int         compares   = 0;
  int         cycles     = 0;
  always #4 core_clk_i = ~core_clk_i;
  i2st_top DUT (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe_o),
    .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
  i2st_master_model u_mst (.scl_i(scl_w), .sda_i(sda_w),
    .scl_low_o(m_scl_low), .sda_low_o(m_sda_low));
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic give_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic chk_pin(input logic p, input logic e);
    check({7'h0, p}, {7'h0, e});
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  task automatic chk_bit(input logic [3:0] a, input int i, input logic e);
    rd_reg(a, v);
    chk_pin(v[i], e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_reset_vals();
    rd_reg(4'h0, v);
    check(v, 8'h04);
    rd_reg(4'h3, v);
    check(v, 8'h2a);
    rd_reg(4'h5, v);
    check(v, 8'h00);
    rd_reg(4'hf, v);
    check(v, 8'h00);
    check({6'h0, irq_o, scl_oe_o}, 8'h00);
  endtask
  task automatic t_start();
    wr_reg(4'h5, 8'h07);
    wr_reg(4'h0, 8'h07);
    u_mst.start();
    settle(8);
    chk_bit(4'h1, 5, 1'b1);
    chk_pin(irq_o, 1'b1);
    wr_reg(4'h4, 8'h07);
    settle(2);
    chk_pin(irq_o, 1'b0);
  endtask
  task automatic t_addr_hold();
    u_mst.send_byte(8'h55);
    settle(6);
    chk_pin(scl_oe_o, 1'b1);
    chk_pin(irq_o, 1'b1);
    settle(20);
    chk_pin(irq_o, 1'b1);
    chk_bit(4'h1, 1, 1'b1);
    chk_bit(4'h1, 2, 1'b0);
    chk_bit(4'h1, 3, 1'b1);
    chk_bit(4'h1, 0, 1'b1);
    rd_reg(4'h2, v);
    check(v, 8'h55);
    chk_bit(4'h1, 0, 1'b0);
    wr_reg(4'h2, 8'h99);
    chk_bit(4'h1, 0, 1'b0);
    wr_reg(4'h4, 8'h01);
  endtask
  task automatic t_addr_ack();
    wr_reg(4'h0, 8'h07);
    settle(3);
    chk_pin(scl_oe_o, 1'b0);
    u_mst.get_bit(b);
    chk_pin(b, 1'b0);
    settle(6);
    chk_pin(scl_oe_o, 1'b1);
    chk_pin(irq_o, 1'b1);
    wr_reg(4'h4, 8'h01);
  endtask
  // one transmitted byte, loaded while the master is stretched
  task automatic t_byte(input logic [7:0] d, input logic last);
    logic [7:0] got;
    fork
      u_mst.read_byte(got);
      begin
        settle(40);
        chk_pin(scl_w, 1'b0);
        wr_reg(4'h2, d);
        chk_bit(4'h1, 0, 1'b1);
        wr_reg(4'h0, 8'h07);
      end
    join
    check(got, d);
    u_mst.send_bit(last);
    settle(6);
    chk_bit(4'h1, 4, last);
    chk_pin(scl_oe_o, !last);
    if (last)
      chk_pin(sda_oe_o, 1'b0);
    if (!last)
      wr_reg(4'h4, 8'h01);
    else
      u_mst.stop();
  endtask
  // ----------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    t_reset_vals();
    t_start();
    t_addr_hold();
    t_addr_ack();
    t_byte(8'ha5, 1'b0);
    t_byte(8'h3c, 1'b1);
    settle(6);
    chk_bit(4'h1, 6, 1'b1);
    check(u_mst.errs[7:0], 8'h00);
    give_verdict();
  end
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end
endmodule
